// ===== core/alarm_status_flag_aggregator.sv
`timescale 1ns/1ps
module alarm_status_flag_aggregator #(
    parameter int NUM_EQ = flag_pkg::NUM_EQ
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [11:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [11:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic [5:0] i_class_active,
    input wire logic [5:0] i_class_latched,
    input wire logic [5:0] i_alarm_trigger,
    input wire logic i_ack,
    input wire logic [2:0] i_volt_ok,
    input wire logic [2:0] i_freq_ok,
    input wire logic [1:0] i_rot_ccw,
    input wire logic [1:0] i_rot_cw,
    input wire logic [15:0] i_volt_aux,
    input wire logic [15:0] i_volt_a,
    input wire logic [15:0] i_volt_b,
    input wire logic [1:0] i_mains_conn,
    input wire logic [1:0] i_variable,
    input wire logic i_breaker_a_closed,
    input wire logic i_generator_breaker_closed,
    input wire logic i_slip_ok,
    input wire logic i_angle_ok,
    input wire logic i_vdiff_ok,
    input wire logic i_dead_bus_cond,
    input wire logic [15:0] i_ext_cmd,
    output logic [39:0] o_flags,
    output logic [NUM_EQ-1:0] o_results
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [39:0] flags_d;                     // Next derived flags
    logic [39:0] flags_q;                     // Derived flags
    logic [NUM_EQ-1:0] results_q;             // Slot results
    logic [15:0] horn_cnt_q;                  // Horn time left
    logic [15:0] horn_cnt_d;
    logic [31:0] horn_time_q;                 // Horn reset ticks
    logic [31:0] dead_thr_q;                  // Dead bus threshold, exclusive
    logic [31:0] cfg_q;                       // Bit0 A, bit1 B 3-phase
    logic [20:0] sel_q [NUM_EQ];              // Input indices
    logic [11:0] mode_q [NUM_EQ];             // Signs and operators
    logic [NUM_EQ-1:0] chain [NUM_EQ+1];      // Results per stage
    logic [63:0] base;                        // Non-result variables
    logic aw_q;                               // Write address held
    logic w_q;                                // Write data held
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++)
        begin
            merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    // Equation page hit
    function automatic logic eq_hit(input logic [11:0] a);
        eq_hit = (a[11:8] == flag_pkg::A_EQ_PAGE)
            && (32'(a[7:3]) < NUM_EQ);
    endfunction

    // Replace one bit of a result vector
    function automatic logic [NUM_EQ-1:0] put_bit(
        input logic [NUM_EQ-1:0] v, input int k, input logic b);
        put_bit = v;
        put_bit[k] = b;
    endfunction

    // ------------------------------------------------------------
    // Flag derivation
    // ------------------------------------------------------------
    wire [5:0] cls = i_class_active | i_class_latched;
    wire new_trig = |i_alarm_trigger[5:1];
    wire [2:0] hlth = i_volt_ok & i_freq_ok;
    wire [15:0] thr = dead_thr_q[15:0];
    wire mpar = ((i_mains_conn[0] & i_variable[1])
        | (i_mains_conn[1] & i_variable[0]))
        & i_breaker_a_closed & i_generator_breaker_closed;
    wire scond = i_slip_ok & i_angle_ok & i_vdiff_ok;

    // Horn countdown: reload on trigger, otherwise run down
    assign horn_cnt_d = new_trig ? horn_time_q[15:0]
        : (horn_cnt_q != 16'h0000) ? horn_cnt_q - 16'h0001
        : 16'h0000;

    // Assemble next flags
    always_comb
    begin
        flags_d = '0;
        flags_d[flag_pkg::V_CLASS +: 6] = cls;
        flags_d[flag_pkg::V_ANY] = |cls;
        flags_d[flag_pkg::V_WARN] = |cls[1:0];
        flags_d[flag_pkg::V_SHUT] = |cls[5:2];
        flags_d[flag_pkg::V_CENT] = |cls[5:1];
        // Set wins over acknowledge
        flags_d[flag_pkg::V_NEW] = new_trig
            | (flags_q[flag_pkg::V_NEW] & ~i_ack);
        flags_d[flag_pkg::V_HORN] = horn_cnt_d != 16'h0000;
        for (int s = 0; s < 3; s++)
        begin
            flags_d[flag_pkg::V_RANGE + 3*s] = i_volt_ok[s];
            flags_d[flag_pkg::V_RANGE + 3*s + 1] = i_freq_ok[s];
            flags_d[flag_pkg::V_RANGE + 3*s + 2] = hlth[s];
        end
        for (int s = 0; s < 2; s++)
        begin
            flags_d[flag_pkg::V_ROT + 2*s] = i_rot_ccw[s] & cfg_q[s];
            flags_d[flag_pkg::V_ROT + 2*s + 1] = i_rot_cw[s] & cfg_q[s];
        end
        flags_d[flag_pkg::V_DEAD] = i_volt_aux < thr;
        flags_d[flag_pkg::V_DEAD + 1] = i_volt_a < thr;
        flags_d[flag_pkg::V_DEAD + 2] = i_volt_b < thr;
        flags_d[flag_pkg::V_MPAR] = mpar;
        flags_d[flag_pkg::V_SREL] = scond | i_dead_bus_cond;
        flags_d[flag_pkg::V_SCOND] = scond;
        flags_d[flag_pkg::V_DCOND] = i_dead_bus_cond;
    end

    // Variables below the results; constants bypass reset
    assign base = {8'h00, i_ext_cmd, 6'h00, flags_q[33:2],
        1'b1, 1'b0};

    // Per-tick flag and horn registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            flags_q <= '0;
            horn_cnt_q <= 16'h0000;
            results_q <= '0;
        end
        else
        begin
            flags_q <= flags_d;
            horn_cnt_q <= horn_cnt_d;
            results_q <= chain[NUM_EQ];
        end
    end

    // ------------------------------------------------------------
    // Equation slots, cascaded first to last
    // ------------------------------------------------------------
    assign chain[0] = results_q;
    for (genvar k = 0; k < NUM_EQ; k++)
    begin : g_eq
        eqn_if u_if ();
        // Earlier slots already updated this tick
        wire [flag_pkg::VAR_N-1:0] vars = {
            {(flag_pkg::VAR_N - flag_pkg::BASE_N - NUM_EQ){1'b0}},
            chain[k], base};
        for (genvar j = 0; j < 3; j++)
        begin : g_in
            assign u_if.arg[j] = vars[sel_q[k][7*j +: 7]];
            assign u_if.sign[j] = flag_pkg::sign_e'(mode_q[k][2*j +: 2]);
        end
        for (genvar j = 0; j < 2; j++)
        begin : g_op
            assign u_if.op[j] = flag_pkg::op_e'(mode_q[k][6+3*j +: 3]);
        end
        logic_equation u_eq (
            .bus(u_if.eval)
        );
        assign chain[k+1] = put_bit(chain[k], k, u_if.result);
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign o_awready = !aw_q && !bvalid_q;
    assign o_wready = !w_q && !bvalid_q;
    assign o_arready = !rvalid_q;
    wire do_wr = aw_q && w_q;                 // Both halves present
    wire [4:0] wr_eq = awaddr_q[7:3];
    wire [4:0] rd_eq = i_araddr[7:3];
    wire wr_map = eq_hit(awaddr_q) || awaddr_q == flag_pkg::A_HORN
        || awaddr_q == flag_pkg::A_DEAD || awaddr_q == flag_pkg::A_CFG;
    wire [11:0] ra = {i_araddr[11:2], 2'b00};
    wire rd_eqh = eq_hit(ra);
    wire rd_map = rd_eqh || ra == flag_pkg::A_HORN
        || ra == flag_pkg::A_DEAD || ra == flag_pkg::A_CFG
        || ra == flag_pkg::A_FLAGS || ra == flag_pkg::A_FLAGH
        || ra == flag_pkg::A_RES;
    wire [31:0] rd_val =
        (ra == flag_pkg::A_HORN) ? horn_time_q
        : (ra == flag_pkg::A_DEAD) ? dead_thr_q
        : (ra == flag_pkg::A_CFG) ? cfg_q
        : (ra == flag_pkg::A_FLAGS) ? flags_q[31:0]
        : (ra == flag_pkg::A_FLAGH) ? {24'h00_0000, flags_q[39:32]}
        : (ra == flag_pkg::A_RES) ? 32'(results_q)
        : !rd_eqh ? 32'h0000_0000
        : i_araddr[2] ? {20'h0_0000, mode_q[rd_eq]}
        : {11'h000, sel_q[rd_eq]};

    // Write channel capture and response
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= flag_pkg::RESP_OK;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= {i_awaddr[11:2], 2'b00};
            end
            if (i_wvalid && o_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_wr)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? flag_pkg::RESP_OK : flag_pkg::RESP_ERR;
            end
            else if (bvalid_q && i_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register file writes
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            horn_time_q <= flag_pkg::HORN_RST;
            dead_thr_q <= flag_pkg::DEAD_RST;
            cfg_q <= flag_pkg::CFG_RST;
            for (int k = 0; k < NUM_EQ; k++)
            begin
                sel_q[k] <= 21'h00_0000;
                mode_q[k] <= 12'h000;
            end
        end
        else if (do_wr)
        begin
            if (awaddr_q == flag_pkg::A_HORN)
                horn_time_q <= merge(horn_time_q, wdata_q, wstrb_q);
            if (awaddr_q == flag_pkg::A_DEAD)
                dead_thr_q <= merge(dead_thr_q, wdata_q, wstrb_q);
            if (awaddr_q == flag_pkg::A_CFG)
                cfg_q <= merge(cfg_q, wdata_q, wstrb_q) & 32'h0000_0003;
            if (eq_hit(awaddr_q) && !awaddr_q[2])
                sel_q[wr_eq] <= 21'(merge(32'(sel_q[wr_eq]),
                    wdata_q, wstrb_q));
            if (eq_hit(awaddr_q) && awaddr_q[2])
                mode_q[wr_eq] <= 12'(merge(32'(mode_q[wr_eq]),
                    wdata_q, wstrb_q));
        end
    end

    // Read channel
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= flag_pkg::RESP_OK;
        end
        else if (i_arvalid && o_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_map ? flag_pkg::RESP_OK : flag_pkg::RESP_ERR;
        end
        else if (rvalid_q && i_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_flags = {flags_q[39:2], 1'b1, 1'b0};
    assign o_results = results_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Trigger of any class above A
    sequence s_trigger;
        |i_alarm_trigger[5:1];
    endsequence
    // New alarm standing, no acknowledge, no fresh trigger
    sequence s_hold_new;
        flags_q[flag_pkg::V_NEW] && !i_ack && !(|i_alarm_trigger[5:1]);
    endsequence
    // Trigger while the horn time is five ticks
    sequence s_horn_start;
        s_trigger ##0 (horn_time_q == 32'h0000_0005);
    endsequence

    a_class_follow: assert property (
        1 |=> flags_q[7:2] == $past(i_class_active | i_class_latched))
        else $error("class flag mismatch");
    a_summary_or: assert property (
        flags_q[flag_pkg::V_SHUT] == |flags_q[7:4]
        && flags_q[flag_pkg::V_CENT] == |flags_q[7:3]
        && flags_q[flag_pkg::V_WARN] == |flags_q[3:2])
        else $error("summary flag mismatch");
    a_new_alarm_set: assert property (
        s_trigger |=> flags_q[flag_pkg::V_NEW])
        else $error("new alarm not set");
    a_new_alarm_hold: assert property (
        s_hold_new |=> flags_q[flag_pkg::V_NEW])
        else $error("new alarm not held");
    a_horn_time: assert property (
        s_horn_start |=> flags_q[flag_pkg::V_HORN] [*5])
        else $error("horn ended early");
    a_healthy_and: assert property (
        1 |=> flags_q[16] == $past(i_volt_ok[0] && i_freq_ok[0])
        && flags_q[19] == $past(i_volt_ok[1] && i_freq_ok[1])
        && flags_q[22] == $past(i_volt_ok[2] && i_freq_ok[2]))
        else $error("healthy flag mismatch");
    a_rotation_gate: assert property (
        !cfg_q[1] |=> !flags_q[flag_pkg::V_ROT + 2]
        && !flags_q[flag_pkg::V_ROT + 3])
        else $error("rotation without three phase");
    a_dead_thresh: assert property (
        i_volt_a < dead_thr_q[15:0] |=> flags_q[flag_pkg::V_DEAD + 1])
        else $error("dead flag missing");
    a_mains_par: assert property (
        !i_breaker_a_closed |=> !flags_q[flag_pkg::V_MPAR])
        else $error("mains parallel with breaker open");
    a_sync_relay: assert property (
        1 |=> flags_q[flag_pkg::V_SREL] == $past(i_dead_bus_cond
        || (i_slip_ok && i_angle_ok && i_vdiff_ok)))
        else $error("sync relay mismatch");
    a_reset_clear: assert property (
        @(posedge i_clk) disable iff (1'b0)
        !i_rst_b |=> flags_q == '0 && results_q == '0)
        else $error("flags not cleared");
endmodule

// ===== core/flag_pkg.sv
package flag_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_EQ = 20;      // Result slots, first to last
    localparam int IDX_W = 7;        // Variable index width
    localparam int VAR_N = 128;      // Selectable variables
    localparam int BASE_N = 64;      // Variables below the results
    localparam int FLAG_N = 40;      // Derived flag vector width
    localparam int ADDR_W = 12;      // Register byte address width
    localparam int HORN_W = 16;      // Horn timer width
    localparam int VOLT_W = 16;      // Measured voltage width

    // ------------------------------------------------------------
    // Variable indices
    // ------------------------------------------------------------
    localparam int V_FALSE = 0;      // Constant false
    localparam int V_TRUE = 1;       // Constant true
    localparam int V_CLASS = 2;      // Classes A..F at 2..7
    localparam int V_ANY = 8;        // Any class
    localparam int V_WARN = 9;       // Warning summary
    localparam int V_SHUT = 10;      // Shutdown summary
    localparam int V_CENT = 11;      // Centralized summary
    localparam int V_NEW = 12;       // New alarm
    localparam int V_HORN = 13;      // Horn
    localparam int V_RANGE = 14;     // B v,f,ok; aux v,f,ok; A v,f,ok
    localparam int V_ROT = 23;       // A ccw, A cw, B ccw, B cw
    localparam int V_DEAD = 27;      // Aux, A, B dead
    localparam int V_MPAR = 30;      // Mains parallel
    localparam int V_SREL = 31;      // Sync check relay
    localparam int V_SCOND = 32;     // Phase matching condition
    localparam int V_DCOND = 33;     // Dead bus closure condition
    localparam int V_EXT = 40;       // External commands 40..55
    localparam int V_RES = 64;       // Result slots 64..83

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] A_HORN = 12'h000;  // Horn reset ticks
    localparam logic [11:0] A_DEAD = 12'h004;  // Dead bus threshold
    localparam logic [11:0] A_CFG = 12'h008;   // Three-phase enables
    localparam logic [11:0] A_FLAGS = 12'h010; // Flags 31..0
    localparam logic [11:0] A_FLAGH = 12'h014; // Flags 39..32
    localparam logic [11:0] A_RES = 12'h018;   // Result slots
    localparam logic [3:0] A_EQ_PAGE = 4'h1;   // Equation page 0x1xx
    localparam logic [31:0] HORN_RST = 32'h0000_0064;
    localparam logic [31:0] DEAD_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST = 32'h0000_0003;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // ------------------------------------------------------------
    // Equation encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SIGN_PASS = 2'h0,
        SIGN_NOT = 2'h1,
        SIGN_FALSE = 2'h2,
        SIGN_TRUE = 2'h3
    } sign_e;

    typedef enum logic [2:0] {
        OP_AND = 3'h0,
        OP_NAND = 3'h1,
        OP_OR = 3'h2,
        OP_NOR = 3'h3,
        OP_XOR = 3'h4,
        OP_XNOR = 3'h5
    } op_e;
endpackage

// ===== core/eqn_if.sv
`timescale 1ns/1ps
// Operands and settings of one equation slot
interface eqn_if;
    logic [2:0] arg;                   // Command inputs 1..3
    flag_pkg::sign_e sign [3];         // Sign stage per input
    flag_pkg::op_e op [2];             // Operators 1 and 2
    logic result;                      // Equation output

    modport drive (output arg, output sign, output op, input result);
    modport eval (input arg, input sign, input op, output result);
endinterface

// ===== core/logic_equation.sv
`timescale 1ns/1ps
module logic_equation (
    eqn_if.eval bus
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Sign stage; forced values ignore the command
    function automatic logic apply_sign(input logic v,
                                        input flag_pkg::sign_e s);
        case (s)
            flag_pkg::SIGN_PASS: apply_sign = v;
            flag_pkg::SIGN_NOT: apply_sign = ~v;
            flag_pkg::SIGN_FALSE: apply_sign = 1'b0;
            flag_pkg::SIGN_TRUE: apply_sign = 1'b1;
            default: apply_sign = 1'b0;
        endcase
    endfunction

    // Two-input operator
    function automatic logic apply_op(input logic a, input logic b,
                                      input flag_pkg::op_e o);
        case (o)
            flag_pkg::OP_AND: apply_op = a & b;
            flag_pkg::OP_NAND: apply_op = ~(a & b);
            flag_pkg::OP_OR: apply_op = a | b;
            flag_pkg::OP_NOR: apply_op = ~(a | b);
            flag_pkg::OP_XOR: apply_op = a ^ b;
            flag_pkg::OP_XNOR: apply_op = ~(a ^ b);
            default: apply_op = a & b;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------
    wire s1 = apply_sign(bus.arg[0], bus.sign[0]);
    wire s2 = apply_sign(bus.arg[1], bus.sign[1]);
    wire s3 = apply_sign(bus.arg[2], bus.sign[2]);
    wire first = apply_op(s1, s2, bus.op[0]);
    assign bus.result = apply_op(first, s3, bus.op[1]);
endmodule

// ===== sim/test_alarm_status_flag_aggregator.sv
`timescale 1ns/1ps
module test_alarm_status_flag_aggregator;
// ----------------
// Bench signals
// ----------------
logic i_clk = 0, i_rst_b = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
logic i_arvalid = 0, i_rready = 0, i_ack = 0, i_breaker_a_closed = 0;
logic i_generator_breaker_closed = 0, i_slip_ok = 0, i_angle_ok = 0;
logic i_vdiff_ok = 0, i_dead_bus_cond = 0;
logic [11:0] i_awaddr = '0, i_araddr = '0;
logic [31:0] i_wdata = '0, o_rdata, rdv;
logic [3:0] i_wstrb = '0;
logic [5:0] i_class_active = '0, i_class_latched = '0, i_alarm_trigger = '0;
logic [2:0] i_volt_ok = '0, i_freq_ok = '0, o2;
logic [1:0] i_rot_ccw = '0, i_rot_cw = '0, i_mains_conn = '0, i_variable = '0;
logic [15:0] i_volt_aux = '0, i_volt_a = '0, i_volt_b = '0, i_ext_cmd = '0;
logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, e;
logic [1:0] o_bresp, o_rresp, rs, cfg = 2'h3;
logic [39:0] o_flags, ef, h;
logic [19:0] o_results;
logic [15:0] thr = '0;
logic [95:0] r;
int n_fail = 0, check_count = 0, cyc = 0;
localparam logic [39:0] M = 40'hff_ffff_cfff; // Horn and new alarm apart

alarm_status_flag_aggregator dut (.*);

always #50 i_clk = ~i_clk;

// ----------------
// Helpers
// ----------------
task automatic chk(input string n, input logic [39:0] x, g);
    check_count++;
    if (g !== x)
    begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", n, x, g);
    end
endtask

task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask

// Write: both channels offered together, each released when taken
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge i_clk);
    {i_awvalid, i_wvalid, i_bready, i_wstrb} <= 7'h7f;
    {i_awaddr, i_wdata} <= {a, d};
    do
    begin
        @(negedge i_clk);
        {aw, w, b, rs} = {i_awvalid & o_awready, i_wvalid & o_wready,
            o_bvalid, o_bresp};
        @(posedge i_clk);
        if (aw) i_awvalid <= 1'h0;
        if (w) i_wvalid <= 1'h0;
    end while (!b);
    i_bready <= 1'h0;
endtask

// Read one word and compare response and data
task automatic rchk(input logic [11:0] a, input logic [1:0] xr,
    input logic [31:0] xd);
    logic ar, v;
    @(posedge i_clk);
    {i_arvalid, i_rready, i_araddr} <= {2'h3, a};
    do
    begin
        @(negedge i_clk);
        {ar, v, rs, rdv} = {i_arvalid & o_arready, o_rvalid, o_rresp,
            o_rdata};
        @(posedge i_clk);
        if (ar) i_arvalid <= 1'h0;
    end while (!v);
    i_rready <= 1'h0;
    chk("read", {6'h00, xr, xd}, {6'h00, rs, rdv});
endtask

// Flag model from the present input levels
function automatic logic [39:0] model();
    logic [5:0] c;
    logic [39:0] f;
    c = i_class_active | i_class_latched;
    f = 40'h00_0000_0002;
    f[11:2] = {|c[5:1], |c[5:2], |c[1:0], |c, c};
    for (int s = 0; s < 3; s++)
        f[14+3*s +: 3] = {i_volt_ok[s] & i_freq_ok[s], i_freq_ok[s],
            i_volt_ok[s]};
    f[26:23] = {i_rot_cw[1], i_rot_ccw[1], i_rot_cw[0], i_rot_ccw[0]}
        & {{2{cfg[1]}}, {2{cfg[0]}}};
    f[29:27] = {i_volt_b < thr, i_volt_a < thr, i_volt_aux < thr};
    f[30] = ((i_mains_conn[0] & i_variable[1]) | (i_mains_conn[1]
        & i_variable[0])) & i_breaker_a_closed & i_generator_breaker_closed;
    f[32] = i_slip_ok & i_angle_ok & i_vdiff_ok;
    f[33] = i_dead_bus_cond;
    f[31] = f[32] | f[33];
    return f;
endfunction

function automatic logic sg(input logic [1:0] s, input logic v);
    return s[1] ? s[0] : v ^ s[0];
endfunction

function automatic logic op(input logic [2:0] o, input logic a, b);
    return (o[2] ? a ^ b : o[1] ? a | b : a & b) ^ o[0];
endfunction

// Random levels every tick, flags compared one tick later
task automatic rnd(input int n);
    for (int i = 0; i <= n; i++)
    begin
        @(posedge i_clk);
        r = {$urandom, $urandom, $urandom};
        {i_class_active, i_class_latched, i_volt_ok, i_freq_ok, i_rot_ccw,
            i_rot_cw} <= r[21:0];
        {i_mains_conn, i_variable, i_breaker_a_closed, i_slip_ok, i_angle_ok,
            i_generator_breaker_closed, i_vdiff_ok, i_dead_bus_cond,
            i_ext_cmd} <= r[47:22];
        {i_volt_aux, i_volt_a, i_volt_b} <= r[95:48];
        @(negedge i_clk);
        if (i > 0) chk("flags", ef & M, o_flags & M);
        ef = model();
    end
endtask

// Horn ticks and new alarm after one trigger
task automatic alarm(input logic [5:0] t, input logic [39:0] xh, xn);
    @(posedge i_clk) i_alarm_trigger <= t;
    @(posedge i_clk) i_alarm_trigger <= 6'h00;
    h = '0;
    repeat (12)
    begin
        @(negedge i_clk);
        if (o_flags[13] === 1'h1) h++;
    end
    chk("horn", xh, h);
    chk("new", xn, {39'h0, o_flags[12]});
    @(posedge i_clk) i_ack <= 1'h1;
    @(posedge i_clk) i_ack <= 1'h0;
    repeat (2) @(negedge i_clk);
    chk("new_ack", 40'h0, {39'h0, o_flags[12]});
endtask

always @(posedge i_clk)
begin
    cyc++;
    if (cyc == 5000)
    begin
        n_fail++;
        summarize();
    end
end

// ----------------
// Main sequence
// ----------------
initial
begin
    void'($urandom(32'h0000_2a48));
    repeat (8) @(posedge i_clk);
    chk("reset", 40'h00_0000_0002, o_flags);
    i_rst_b <= 1'h1;
    rchk(12'h000, 2'h0, 32'h0000_0064);
    rchk(12'h008, 2'h0, 32'h0000_0003);
    wr(12'h010, 32'hffff_ffff);
    chk("bresp", 40'h2, {38'h0, rs});
    rchk(12'h00c, 2'h2, 32'h0000_0000);
    rnd(200);
    wr(12'h004, 32'h0000_8000);
    wr(12'h008, 32'h0000_0001);
    {thr, cfg} = {16'h8000, 2'h1};
    rnd(200);
    wr(12'h000, 32'h0000_0005);
    alarm(6'h04, 40'h5, 40'h1);
    alarm(6'h01, 40'h0, 40'h0);
    wr(12'h100, 32'h000a_94a8);
    wr(12'h108, 32'h0000_40c0);
    for (int k = 0; k < 6; k++)
    begin
        r = {$urandom, $urandom, $urandom};
        o2 = {1'h0, r[9:8]} + {1'h0, r[10], 1'h0};
        wr(12'h104, {20'h0_0000, o2, k[2:0], r[5:0]});
        @(posedge i_clk) i_ext_cmd <= r[31:16];
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        e = op(o2, op(k[2:0], sg(r[1:0], r[16]), sg(r[3:2], r[17])),
            sg(r[5:4], r[18]));
        chk("eqn", {38'h0, e, e}, {38'h0, o_results[1:0]});
        chk("results", {38'h0, e, e}, {20'h0, o_results});
    end
    rchk(12'h108, 2'h0, 32'h0000_40c0);
    rchk(12'h018, 2'h0, {30'h0, e, e});
    summarize();
end
endmodule
